// *** logic/hrc_map.svh ***
`ifndef HRC_MAP_SVH
`define HRC_MAP_SVH

// ----------------------------------------
// port count, rates
// ----------------------------------------
`define HRC_NPORTS      4
`define HRC_CLK_MHZ     40
`define HRC_HS_MBPS     480
`define HRC_FS_MBPS     12

// ----------------------------------------
// (micro)frame period window, bit times and clock cycles
// ----------------------------------------
`define HRC_HS_MIN_BITS 59904
`define HRC_HS_MAX_BITS 60096
`define HRC_FS_MIN_BITS 11958
`define HRC_FS_MAX_BITS 12042
`define HRC_HS_MIN_CYC  ((`HRC_HS_MIN_BITS * `HRC_CLK_MHZ + `HRC_HS_MBPS - 1) / `HRC_HS_MBPS)
`define HRC_HS_MAX_CYC  ((`HRC_HS_MAX_BITS * `HRC_CLK_MHZ) / `HRC_HS_MBPS)
`define HRC_FS_MIN_CYC  ((`HRC_FS_MIN_BITS * `HRC_CLK_MHZ + `HRC_FS_MBPS - 1) / `HRC_FS_MBPS)
`define HRC_FS_MAX_CYC  ((`HRC_FS_MAX_BITS * `HRC_CLK_MHZ) / `HRC_FS_MBPS)
`define HRC_TMR_W       16

// ----------------------------------------
// hub controller answer timeout, bit times and clock cycles
// ----------------------------------------
`define HRC_HS_TMO_BITS 816
`define HRC_FS_TMO_BITS 18
`define HRC_HS_TMO_CYC  ((`HRC_HS_TMO_BITS * `HRC_CLK_MHZ + `HRC_HS_MBPS - 1) / `HRC_HS_MBPS)
`define HRC_FS_TMO_CYC  ((`HRC_FS_TMO_BITS * `HRC_CLK_MHZ + `HRC_FS_MBPS - 1) / `HRC_FS_MBPS)
`define HRC_TMO_W       7

`endif

// *** logic/hrc_pkg.sv ***
package hrc_pkg;

  typedef struct packed {
    logic hs_dev;
    logic enabled;
    logic suspended;
    logic pkt_start;
    logic pkt_end;
    logic resume;
  } hrc_ds_type;

  typedef struct packed {
    logic hs;
    logic pkt_start;
    logic pkt_end;
    logic resume;
  } hrc_us_type;

  typedef struct packed {
    logic fs_rep;
    logic hs_rep;
    logic tt;
  } hrc_func_type;

  typedef enum logic [1:0] {
    HRC_IDLE   = 2'h0,
    HRC_DOWN   = 2'h1,
    HRC_UP     = 2'h2,
    HRC_RESUME = 2'h3
  } hrc_conn_type;

endpackage : hrc_pkg

// *** logic/hrc_port_route.sv ***
`timescale 1ns/1ps
module hrc_port_route (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                hs_mode,
  input  wire hrc_pkg::hrc_ds_type ds_pin,
  output hrc_pkg::hrc_ds_type      ds_sync,
  output logic                     to_tt,
  output logic                     rep_ok,
  output logic                     res_ok,
  output logic                     res_req
);
  hrc_pkg::hrc_ds_type s1_q;
  hrc_pkg::hrc_ds_type s2_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= ds_pin;
      s2_q <= s1_q;
    end
  end

  assign ds_sync = s2_q;
  assign to_tt   = hs_mode & ~s2_q.hs_dev;
  assign rep_ok  = s2_q.enabled & ~s2_q.suspended & ~to_tt;
  assign res_ok  = s2_q.enabled & ~s2_q.suspended;
  assign res_req = s2_q.resume & (s2_q.enabled | s2_q.suspended);
endmodule : hrc_port_route

// *** logic/hrc_frame_timer.sv ***
`timescale 1ns/1ps
`include "hrc_map.svh"
module hrc_frame_timer #(
  parameter int unsigned HS_MIN = `HRC_HS_MIN_CYC,
  parameter int unsigned HS_MAX = `HRC_HS_MAX_CYC,
  parameter int unsigned FS_MIN = `HRC_FS_MIN_CYC,
  parameter int unsigned FS_MAX = `HRC_FS_MAX_CYC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic restart,
  input  wire logic hs_mode,
  input  wire logic sof,
  output logic      locked_q,
  output logic      eof_q
);
  logic [`HRC_TMR_W-1:0] cur_q;
  logic [`HRC_TMR_W-1:0] ftm_q;
  logic [`HRC_TMR_W-1:0] nxt_q;
  logic                  rolled_q;
  logic                  armed_q;
  wire  [`HRC_TMR_W-1:0] lo     = hs_mode ? `HRC_TMR_W'(HS_MIN) : `HRC_TMR_W'(FS_MIN);
  wire  [`HRC_TMR_W-1:0] hi     = hs_mode ? `HRC_TMR_W'(HS_MAX) : `HRC_TMR_W'(FS_MAX);
  wire                   in_rng = armed_q & ~rolled_q & (cur_q >= lo) & (cur_q <= hi);
  wire                   at_end = locked_q & (ftm_q == '0);

  // cur counts cycles since the last sof; a period outside the window keeps nxt_q
  // but still reloads ftm_q from it, so one glitch sof re-phases the timer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cur_q    <= '0;
      ftm_q    <= '0;
      nxt_q    <= '0;
      rolled_q <= 1'b0;
      armed_q  <= 1'b0;
      locked_q <= 1'b0;
      eof_q    <= 1'b0;
    end else if (restart) begin
      cur_q    <= '0;
      ftm_q    <= '0;
      nxt_q    <= '0;
      rolled_q <= 1'b0;
      armed_q  <= 1'b0;
      locked_q <= 1'b0;
      eof_q    <= 1'b0;
    end else if (sof) begin
      cur_q    <= `HRC_TMR_W'(1);
      rolled_q <= 1'b0;
      armed_q  <= 1'b1;
      eof_q    <= at_end;
      if (in_rng) begin
        ftm_q    <= cur_q - `HRC_TMR_W'(1);
        nxt_q    <= cur_q - `HRC_TMR_W'(1);
        locked_q <= 1'b1;
      end else if (locked_q) begin
        ftm_q    <= nxt_q;
      end
    end else begin
      cur_q    <= rolled_q ? cur_q : cur_q + `HRC_TMR_W'(1);
      rolled_q <= rolled_q | (cur_q > hi);
      eof_q    <= at_end;
      if (at_end) begin
        ftm_q <= nxt_q;
      end else if (locked_q) begin
        ftm_q <= ftm_q - `HRC_TMR_W'(1);
      end
    end
  end

  a_lock_after_sof: assert property (@(posedge clock) disable iff (!resetn)
    $rose(locked_q) |-> $past(sof) && $past(armed_q))
    else $error("timer locked without two in-range sofs");

  a_reload_next: assert property (@(posedge clock) disable iff (!resetn)
    (at_end && !sof && !restart) |=> eof_q && ftm_q == $past(nxt_q))
    else $error("timer did not reload the stored period at zero");
endmodule : hrc_frame_timer

// *** logic/hrc_core.sv ***
`timescale 1ns/1ps
`include "hrc_map.svh"

// Contract
// - upstream port linked at high speed makes the whole hub run at high speed.
// - upstream port linked at full speed makes the hub run at full speed.
// - in full/low-speed surroundings only the full/low-speed repeater works; all ports route to it.
// - at high speed the full/low-speed repeater stays idle.
// - at high speed a port with a high-speed device routes to the repeater.
// - at high speed a port with a full/low-speed device routes to the translator.
// - idle means no connection at all; every port listens for a packet start (the code takes starts only from rep_ok ports while the hub is awake).
// - a packet start on an enabled downstream port connects it upstream only.
// - a packet start upstream is broadcast to every enabled downstream port.
// - a port that is not enabled never carries downstream packet traffic.
// - suspended hub repeats upstream resume to all enabled downstream ports.
// - downstream resume goes upstream and to all enabled ports, originator included.
// - resume never goes to disabled or suspended ports.
// - connectivity fault checking runs only in repeater mode.
// - hub controller times out a missing answer like any other device.
// - a frame timer runs on the local clock, aligned to start-of-frame tokens.
// - the timer keeps host period even across two missed start-of-frame tokens.
// - a high-speed period of 59904 to 60096 bit times is accepted.
// - a full-speed period of 11958 to 12042 bit times is accepted.
// - after reset or resume unlocked; locks on two consecutive start-of-frame tokens.
module hrc_core #(
  parameter int unsigned HS_MIN_CYC = `HRC_HS_MIN_CYC,
  parameter int unsigned HS_MAX_CYC = `HRC_HS_MAX_CYC,
  parameter int unsigned FS_MIN_CYC = `HRC_FS_MIN_CYC,
  parameter int unsigned FS_MAX_CYC = `HRC_FS_MAX_CYC
) (
  input  wire logic                                    clock,
  input  wire logic                                    resetn,
  input  wire hrc_pkg::hrc_us_type                     us_pin,
  input  wire hrc_pkg::hrc_ds_type [`HRC_NPORTS-1:0]   ds_pin,
  input  wire logic                                    hub_suspended,
  input  wire logic                                    sof_det,
  input  wire logic                                    timer_restart,
  input  wire logic                                    hc_expect,
  output logic                                         hs_mode_q,
  output hrc_pkg::hrc_func_type                        func_q,
  output logic [`HRC_NPORTS-1:0]                       route_tt_q,
  output hrc_pkg::hrc_conn_type                        conn_q,
  output logic [1:0]                                   up_src_q,
  output logic                                         us_tx_en_q,
  output logic [`HRC_NPORTS-1:0]                       ds_tx_en_q,
  output logic                                         us_res_drv_q,
  output logic [`HRC_NPORTS-1:0]                       ds_res_drv_q,
  output logic [`HRC_NPORTS-1:0]                       fault_en_q,
  output logic                                         frame_locked,
  output logic                                         frame_eof,
  output logic                                         hc_timeout_q
);

  // ----------------------------------------
  // upstream pin synchroniser
  // ----------------------------------------
  hrc_pkg::hrc_us_type us_s1_q;
  hrc_pkg::hrc_us_type us_s2_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      us_s1_q <= '0;
      us_s2_q <= '0;
    end else begin
      us_s1_q <= us_pin;
      us_s2_q <= us_s1_q;
    end
  end

  wire us_start  = us_s2_q.pkt_start;
  wire us_end    = us_s2_q.pkt_end;
  wire us_resume = us_s2_q.resume;

  // ----------------------------------------
  // operating speed
  // ----------------------------------------
  // the speed follows the upstream link only; downstream devices never
  // change it, so a full-speed parent keeps every high-speed path off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hs_mode_q <= 1'b0;
    end else begin
      hs_mode_q <= us_s2_q.hs;
    end
  end

  // ----------------------------------------
  // per-port routing
  // ----------------------------------------
  hrc_pkg::hrc_ds_type [`HRC_NPORTS-1:0] ds_s;
  logic [`HRC_NPORTS-1:0]                to_tt;
  logic [`HRC_NPORTS-1:0]                rep_ok;
  logic [`HRC_NPORTS-1:0]                res_ok;
  logic [`HRC_NPORTS-1:0]                res_req;
  logic [`HRC_NPORTS-1:0]                ds_start;
  logic [`HRC_NPORTS-1:0]                ds_end;

  for (genvar i = 0; i < `HRC_NPORTS; i++) begin : g_port
    hrc_port_route u_route (
      .clock   (clock),
      .resetn  (resetn),
      .hs_mode (hs_mode_q),
      .ds_pin  (ds_pin[i]),
      .ds_sync (ds_s[i]),
      .to_tt   (to_tt[i]),
      .rep_ok  (rep_ok[i]),
      .res_ok  (res_ok[i]),
      .res_req (res_req[i])
    );
    assign ds_start[i] = ds_s[i].pkt_start;
    assign ds_end[i]   = ds_s[i].pkt_end;
  end

  hrc_pkg::hrc_func_type func_d;
  assign func_d.fs_rep = ~hs_mode_q;
  assign func_d.hs_rep = hs_mode_q;
  assign func_d.tt     = hs_mode_q & (|to_tt);

  // ----------------------------------------
  // connectivity selection
  // ----------------------------------------
  wire [`HRC_NPORTS-1:0] ds_req  = ds_start & rep_ok;
  wire                   any_req = |ds_req;
  // fixed priority keeps the choice repeatable when starts collide
  wire [1:0]             up_pick = ds_req[0] ? 2'h0 :
                                   ds_req[1] ? 2'h1 :
                                   ds_req[2] ? 2'h2 : 2'h3;
  wire                   src_end = ds_end[up_src_q] | ~rep_ok[up_src_q];
  wire                   any_res = |res_req;
  wire                   res_act = hub_suspended & (us_resume | any_res);

  hrc_pkg::hrc_conn_type conn_d;
  logic [1:0]            up_src_d;

  // upstream traffic wins a tie with downstream starts: the host owns the
  // bus schedule, so a device start in the same cycle is a collision anyway
  always_comb begin
    conn_d   = conn_q;
    up_src_d = up_src_q;
    case (conn_q)
      hrc_pkg::HRC_IDLE: begin
        if (res_act) begin
          conn_d = hrc_pkg::HRC_RESUME;
        end else if (hub_suspended) begin
          conn_d = hrc_pkg::HRC_IDLE;
        end else if (us_start) begin
          conn_d = hrc_pkg::HRC_DOWN;
        end else if (any_req) begin
          conn_d   = hrc_pkg::HRC_UP;
          up_src_d = up_pick;
        end
      end
      hrc_pkg::HRC_DOWN: begin
        if (us_end || hub_suspended) begin
          conn_d = hrc_pkg::HRC_IDLE;
        end
      end
      hrc_pkg::HRC_UP: begin
        if (src_end || hub_suspended) begin
          conn_d = hrc_pkg::HRC_IDLE;
        end
      end
      hrc_pkg::HRC_RESUME: begin
        if (!res_act) begin
          conn_d = hrc_pkg::HRC_IDLE;
        end
      end
      default: begin
        conn_d = hrc_pkg::HRC_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // drive enables, decoded from the next state so they align with conn_q
  // ----------------------------------------
  wire                   nx_up   = (conn_d == hrc_pkg::HRC_UP);
  wire                   nx_down = (conn_d == hrc_pkg::HRC_DOWN);
  wire                   nx_res  = (conn_d == hrc_pkg::HRC_RESUME);
  wire                   us_tx_d = nx_up;
  wire [`HRC_NPORTS-1:0] ds_tx_d = nx_down ? rep_ok : '0;
  // a selectively suspended originator gets no reflection back
  wire                   us_rd_d = nx_res & any_res;
  wire [`HRC_NPORTS-1:0] ds_rd_d = nx_res ? res_ok : '0;
  // babble and fault checking only for repeater paths of an awake hub
  wire [`HRC_NPORTS-1:0] flt_d   = hub_suspended ? '0 : (rep_ok & ~to_tt);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      conn_q       <= hrc_pkg::HRC_IDLE;
      up_src_q     <= 2'h0;
      func_q       <= '0;
      route_tt_q   <= '0;
      us_tx_en_q   <= 1'b0;
      ds_tx_en_q   <= '0;
      us_res_drv_q <= 1'b0;
      ds_res_drv_q <= '0;
      fault_en_q   <= '0;
    end else begin
      conn_q       <= conn_d;
      up_src_q     <= up_src_d;
      func_q       <= func_d;
      route_tt_q   <= to_tt;
      us_tx_en_q   <= us_tx_d;
      ds_tx_en_q   <= ds_tx_d;
      us_res_drv_q <= us_rd_d;
      ds_res_drv_q <= ds_rd_d;
      fault_en_q   <= flt_d;
    end
  end

  // ----------------------------------------
  // hub controller answer timeout
  // ----------------------------------------
  logic                 wait_q;
  logic [`HRC_TMO_W-1:0] tmo_cnt_q;
  wire  [`HRC_TMO_W-1:0] tmo_lim = hs_mode_q ? `HRC_TMO_W'(`HRC_HS_TMO_CYC)
                                             : `HRC_TMO_W'(`HRC_FS_TMO_CYC);
  wire                   tmo_hit = wait_q & ~us_start & (tmo_cnt_q == tmo_lim - `HRC_TMO_W'(1));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_q       <= 1'b0;
      tmo_cnt_q    <= '0;
      hc_timeout_q <= 1'b0;
    end else begin
      hc_timeout_q <= tmo_hit;
      if (hc_expect) begin
        wait_q    <= 1'b1;
        tmo_cnt_q <= '0;
      end else if (us_start || tmo_hit) begin
        wait_q    <= 1'b0;
      end else if (wait_q) begin
        tmo_cnt_q <= tmo_cnt_q + `HRC_TMO_W'(1);
      end
    end
  end

  // ----------------------------------------
  // frame timer
  // ----------------------------------------
  hrc_frame_timer #(
    .HS_MIN (HS_MIN_CYC),
    .HS_MAX (HS_MAX_CYC),
    .FS_MIN (FS_MIN_CYC),
    .FS_MAX (FS_MAX_CYC)
  ) u_timer (
    .clock    (clock),
    .resetn   (resetn),
    .restart  (timer_restart),
    .hs_mode  (hs_mode_q),
    .sof      (sof_det),
    .locked_q (frame_locked),
    .eof_q    (frame_eof)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_mode_high: assert property (@(posedge clock) disable iff (!resetn)
    us_pin.hs [*4] |-> hs_mode_q)
    else $error("hub not at high speed after upstream high-speed link");

  a_mode_full: assert property (@(posedge clock) disable iff (!resetn)
    !us_pin.hs [*4] |-> !hs_mode_q)
    else $error("hub not at full speed after upstream full-speed link");

  a_fs_routing: assert property (@(posedge clock) disable iff (!resetn)
    !hs_mode_q ##1 !hs_mode_q |-> route_tt_q == '0 && func_q.fs_rep && !func_q.tt)
    else $error("translator path active in full-speed surroundings");

  a_idle_quiet: assert property (@(posedge clock) disable iff (!resetn)
    conn_q == hrc_pkg::HRC_IDLE |-> !us_tx_en_q && ds_tx_en_q == '0 && ds_res_drv_q == '0)
    else $error("idle hub still drives a port");

  a_up_single: assert property (@(posedge clock) disable iff (!resetn)
    conn_q == hrc_pkg::HRC_UP |-> us_tx_en_q && ds_tx_en_q == '0)
    else $error("upstream packet leaked to a downstream port");

  a_down_bcast: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_IDLE && us_start && !hub_suspended)
    |=> conn_q == hrc_pkg::HRC_DOWN && ds_tx_en_q == $past(rep_ok))
    else $error("upstream start not broadcast to enabled ports");

  a_down_enabled: assert property (@(posedge clock) disable iff (!resetn)
    (ds_tx_en_q & ~$past(rep_ok)) == '0)
    else $error("packet driven onto a port that is not enabled");

  a_end_idle: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_DOWN && us_end) |=> conn_q == hrc_pkg::HRC_IDLE ##1 !us_tx_en_q)
    else $error("connectivity kept after end of packet");

  a_first_wins: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_IDLE && !hub_suspended && !us_start && ds_req[0])
    |=> conn_q == hrc_pkg::HRC_UP && up_src_q == 2'h0)
    else $error("lowest port did not win simultaneous starts");

  a_res_mask: assert property (@(posedge clock) disable iff (!resetn)
    (ds_res_drv_q & ~$past(res_ok)) == '0)
    else $error("resume driven onto a disabled or suspended port");

  a_res_down: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_IDLE && hub_suspended && us_resume)
    |=> conn_q == hrc_pkg::HRC_RESUME && ds_res_drv_q == $past(res_ok))
    else $error("upstream resume not reflected downstream");

  a_fault_rep: assert property (@(posedge clock) disable iff (!resetn)
    (fault_en_q & $past(to_tt)) == '0)
    else $error("fault checking enabled on a translator path");

  a_tmo_time: assert property (@(posedge clock) disable iff (!resetn)
    hc_timeout_q |-> $past(tmo_cnt_q) == $past(tmo_lim) - `HRC_TMO_W'(1))
    else $error("answer timeout fired at the wrong count");

  a_tmo_pulse: assert property (@(posedge clock) disable iff (!resetn)
    hc_timeout_q |=> !hc_timeout_q)
    else $error("timeout pulse too long");

  a_hs_functions: assert property (@(posedge clock) disable iff (!resetn)
    hs_mode_q ##1 hs_mode_q |-> func_q.hs_rep && !func_q.fs_rep)
    else $error("wrong repeater at high speed");

  a_resume_up: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_IDLE && hub_suspended && any_res)
    |=> conn_q == hrc_pkg::HRC_RESUME && us_res_drv_q && ds_res_drv_q == $past(res_ok))
    else $error("downstream resume not reflected");

  a_resume_drop: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_RESUME && !res_act)
    |=> conn_q == hrc_pkg::HRC_IDLE && ds_res_drv_q == '0)
    else $error("resume drive kept");

  a_suspend_quiet: assert property (@(posedge clock) disable iff (!resetn)
    hub_suspended |=> !us_tx_en_q && ds_tx_en_q == '0)
    else $error("packet path open while suspended");

  a_up_end: assert property (@(posedge clock) disable iff (!resetn)
    (conn_q == hrc_pkg::HRC_UP && ds_end[up_src_q])
    |=> conn_q == hrc_pkg::HRC_IDLE && !us_tx_en_q)
    else $error("upstream path kept after end");

endmodule : hrc_core

// *** testbench/hrc_far_model.sv ***
`timescale 1ns/1ps
`include "hrc_map.svh"
// ----------------------------------------
// far side: host upstream, devices on the downstream ports
// ----------------------------------------
module hrc_far_model (
  input  wire logic                                clock,
  output hrc_pkg::hrc_us_type                      us_pin,
  output hrc_pkg::hrc_ds_type [`HRC_NPORTS-1:0]    ds_pin,
  output logic                                     sof_det
);
  initial begin
    us_pin  = '0;
    ds_pin  = '0;
    sof_det = 1'b0;
  end

  // pins change just after an edge, so the hub samples settled levels
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic cfg(input logic hs, input logic [3:0] dev, input logic [3:0] en,
                     input logic [3:0] sus);
    step();
    us_pin.hs = hs;
    for (int i = 0; i < 4; i++) begin
      ds_pin[i].hs_dev    = dev[i];
      ds_pin[i].enabled   = en[i];
      ds_pin[i].suspended = sus[i];
    end
  endtask : cfg

  // one pulse per call: a packet start when st is set, a packet end otherwise
  task automatic us_pulse(input logic st);
    step();
    us_pin.pkt_start = st;
    us_pin.pkt_end   = !st;
    step();
    us_pin.pkt_start = 1'b0;
    us_pin.pkt_end   = 1'b0;
  endtask : us_pulse

  task automatic ds_pulse(input logic st, input logic [3:0] who);
    step();
    for (int i = 0; i < 4; i++) begin
      ds_pin[i].pkt_start = st & who[i];
      ds_pin[i].pkt_end   = !st & who[i];
    end
    step();
    for (int i = 0; i < 4; i++) begin
      ds_pin[i].pkt_start = 1'b0;
      ds_pin[i].pkt_end   = 1'b0;
    end
  endtask : ds_pulse

  task automatic res(input logic us, input logic [3:0] who);
    step();
    us_pin.resume = us;
    for (int i = 0; i < 4; i++) begin
      ds_pin[i].resume = who[i];
    end
  endtask : res

  task automatic sof();
    step();
    sof_det = 1'b1;
    step();
    sof_det = 1'b0;
  endtask : sof
endmodule : hrc_far_model

// *** testbench/hub_repeater_connectivity_router_bench.sv ***
`timescale 1ns/1ps
`include "hrc_map.svh"
`define HRC_CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin \
  err_count++; $display("[FAIL] %s exp %0h got %0h", name, exp, got); end end
module hub_repeater_connectivity_router_bench;
  // ----------------------------------------
  // clock, reset, design
  // ----------------------------------------
  logic                                  clock = 1'b0;
  logic                                  resetn = 1'b0;
  logic                                  hub_suspended = 1'b0;
  logic                                  timer_restart = 1'b0;
  logic                                  hc_expect = 1'b0;
  logic                                  sof_det;
  hrc_pkg::hrc_us_type                   us_pin;
  hrc_pkg::hrc_ds_type [`HRC_NPORTS-1:0] ds_pin;
  logic                                  hs_mode_q, us_tx_en_q, us_res_drv_q;
  hrc_pkg::hrc_func_type                 func_q;
  hrc_pkg::hrc_conn_type                 conn_q;
  logic [1:0]                            up_src_q;
  logic [3:0]                            route_tt_q, ds_tx_en_q, ds_res_drv_q, fault_en_q;
  logic                                  frame_locked, frame_eof, hc_timeout_q;
  int                                    err_count = 0;
  int                                    checked = 0;
  int                                    cycles = 0;
  int                                    n;

  always #12.5 clock = ~clock;

  // real frame window; the timer scenario runs at high speed
  hrc_core uut (
    .clock(clock), .resetn(resetn), .us_pin(us_pin), .ds_pin(ds_pin),
    .hub_suspended(hub_suspended), .sof_det(sof_det), .timer_restart(timer_restart),
    .hc_expect(hc_expect), .hs_mode_q(hs_mode_q), .func_q(func_q), .route_tt_q(route_tt_q),
    .conn_q(conn_q), .up_src_q(up_src_q), .us_tx_en_q(us_tx_en_q), .ds_tx_en_q(ds_tx_en_q),
    .us_res_drv_q(us_res_drv_q), .ds_res_drv_q(ds_res_drv_q), .fault_en_q(fault_en_q),
    .frame_locked(frame_locked), .frame_eof(frame_eof), .hc_timeout_q(hc_timeout_q));

  hrc_far_model far (.clock(clock), .us_pin(us_pin), .ds_pin(ds_pin), .sof_det(sof_det));

  task automatic end_sim();
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : wait_cyc

  // cycles from one end-of-frame pulse to the next
  task automatic eof_gap(output int g);
    int k;
    k = 0;
    g = 0;
    while (frame_eof !== 1'b1 && k < 6000) begin
      wait_cyc(1);
      k++;
    end
    do begin
      wait_cyc(1);
      g++;
    end while (frame_eof !== 1'b1 && g < 6000);
  endtask : eof_gap

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_speed();
    far.cfg(1'b1, 4'h1, 4'hF, 4'h0);
    wait_cyc(6);
    `HRC_CHK("hs_mode", 1'b1, hs_mode_q)
    `HRC_CHK("fs_rep off", 1'b0, func_q.fs_rep)
    `HRC_CHK("hs_rep on", 1'b1, func_q.hs_rep)
    `HRC_CHK("route hs", 4'hE, route_tt_q)
    `HRC_CHK("fault hs", 4'h1, fault_en_q)
    far.ds_pulse(1'b1, 4'h2);
    wait_cyc(4);
    `HRC_CHK("tt port start", hrc_pkg::HRC_IDLE, conn_q)
    far.cfg(1'b0, 4'h1, 4'hF, 4'h0);
    wait_cyc(6);
    `HRC_CHK("fs mode", 1'b0, hs_mode_q)
    `HRC_CHK("func fs", 3'h4, func_q)
    `HRC_CHK("route fs", 4'h0, route_tt_q)
    `HRC_CHK("fault fs", 4'hF, fault_en_q)
  endtask : t_speed

  task automatic t_down();
    far.cfg(1'b0, 4'h0, 4'hB, 4'h0);
    wait_cyc(6);
    `HRC_CHK("idle tx", 4'h0, ds_tx_en_q)
    far.us_pulse(1'b1);
    wait_cyc(4);
    `HRC_CHK("down conn", hrc_pkg::HRC_DOWN, conn_q)
    `HRC_CHK("down ports", 4'hB, ds_tx_en_q)
    `HRC_CHK("down no up", 1'b0, us_tx_en_q)
    far.ds_pulse(1'b1, 4'h1);
    wait_cyc(4);
    `HRC_CHK("down holds", hrc_pkg::HRC_DOWN, conn_q)
    far.us_pulse(1'b0);
    wait_cyc(4);
    `HRC_CHK("down end", hrc_pkg::HRC_IDLE, conn_q)
    `HRC_CHK("down end tx", 4'h0, ds_tx_en_q)
  endtask : t_down

  task automatic t_up();
    far.ds_pulse(1'b1, 4'hA);
    wait_cyc(4);
    `HRC_CHK("up conn", hrc_pkg::HRC_UP, conn_q)
    `HRC_CHK("up winner", 2'h1, up_src_q)
    `HRC_CHK("up us tx", 1'b1, us_tx_en_q)
    `HRC_CHK("up no ds", 4'h0, ds_tx_en_q)
    far.ds_pulse(1'b0, 4'h8);
    wait_cyc(4);
    `HRC_CHK("other end", hrc_pkg::HRC_UP, conn_q)
    far.ds_pulse(1'b0, 4'h2);
    wait_cyc(4);
    `HRC_CHK("up end", 1'b0, us_tx_en_q)
  endtask : t_up

  task automatic t_resume();
    far.cfg(1'b0, 4'h0, 4'h7, 4'h2);
    hub_suspended = 1'b1;
    wait_cyc(6);
    `HRC_CHK("fault susp", 4'h0, fault_en_q)
    far.res(1'b0, 4'h4);
    wait_cyc(4);
    `HRC_CHK("res conn", hrc_pkg::HRC_RESUME, conn_q)
    `HRC_CHK("res up", 1'b1, us_res_drv_q)
    `HRC_CHK("res down", 4'h5, ds_res_drv_q)
    far.res(1'b0, 4'h0);
    wait_cyc(4);
    `HRC_CHK("res gone", hrc_pkg::HRC_IDLE, conn_q)
    far.res(1'b1, 4'h0);
    wait_cyc(4);
    `HRC_CHK("us res up", 1'b0, us_res_drv_q)
    `HRC_CHK("us res down", 4'h5, ds_res_drv_q)
    far.res(1'b0, 4'h0);
    wait_cyc(4);
    far.res(1'b0, 4'h2);
    wait_cyc(4);
    `HRC_CHK("sel susp res", 1'b1, us_res_drv_q)
    `HRC_CHK("sel susp down", 4'h5, ds_res_drv_q)
    far.res(1'b0, 4'h8);
    wait_cyc(4);
    `HRC_CHK("disabled res", hrc_pkg::HRC_IDLE, conn_q)
    far.res(1'b0, 4'h0);
    wait_cyc(4);
    hub_suspended = 1'b0;
  endtask : t_resume

  task automatic t_timer();
    far.cfg(1'b1, 4'h1, 4'hF, 4'h0);
    wait_cyc(6);
    far.sof();
    wait_cyc(3);
    `HRC_CHK("one sof", 1'b0, frame_locked)
    repeat (4995) @(posedge clock);
    far.sof();
    wait_cyc(2);
    `HRC_CHK("locked", 1'b1, frame_locked)
    eof_gap(n);
    `HRC_CHK("eof gap", 1'b1, n >= 4999 && n <= 5001)
    wait_cyc(12500);
    `HRC_CHK("missed sofs", 1'b1, frame_locked)
    eof_gap(n);
    `HRC_CHK("free gap", 1'b1, n >= 4999 && n <= 5001)
    timer_restart = 1'b1;
    wait_cyc(1);
    timer_restart = 1'b0;
    wait_cyc(2);
    `HRC_CHK("restart", 1'b0, frame_locked)
  endtask : t_timer

  task automatic t_timeout(input int lim);
    hc_expect = 1'b1;
    wait_cyc(1);
    hc_expect = 1'b0;
    n = 0;
    do begin
      wait_cyc(1);
      n++;
    end while (hc_timeout_q !== 1'b1 && n < 200);
    `HRC_CHK("tmo", 1'b1, n >= lim && n <= lim + 2)
    hc_expect = 1'b1;
    wait_cyc(1);
    hc_expect = 1'b0;
    far.us_pulse(1'b1);
    n = 0;
    repeat (100) begin
      wait_cyc(1);
      n += (hc_timeout_q === 1'b1) ? 1 : 0;
    end
    `HRC_CHK("answered", 0, n)
    far.us_pulse(1'b0);
  endtask : t_timeout

  initial begin
    repeat (2) @(posedge clock);
    #1;
    `HRC_CHK("reset conn", hrc_pkg::HRC_IDLE, conn_q)
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_speed();
    t_down();
    t_up();
    t_resume();
    t_timer();
    t_timeout(`HRC_HS_TMO_CYC);
    far.cfg(1'b0, 4'h0, 4'hB, 4'h0);
    wait_cyc(6);
    t_timeout(`HRC_FS_TMO_CYC);
    end_sim();
  end
endmodule : hub_repeater_connectivity_router_bench
